// ==== rtl/rtci_pkg.sv ====
// Constants and types for the clock's indirect register interface.
// Assumes one system clock; the low-frequency timebase arrives as a plain level.
package rtci_pkg;

  // Special-function register addresses
  localparam logic [7:0] SFR_ADDR_SELECT = 8'hac;
  localparam logic [7:0] SFR_DATA_PORT = 8'had;
  localparam logic [7:0] SFR_KEY_STATUS = 8'hae;

  // Legacy key register always reports the unlocked state
  localparam logic [7:0] KEY_UNLOCKED = 8'h02;

  // Address register layout and reset
  localparam int ADR_AUTOREAD_ENABLE_BIT = 6;
  localparam int ADR_FIELD_W = 5;
  localparam logic [7:0] ADR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Internal register addresses
  localparam logic [4:0] IA_CAPTURE0 = 5'h00;
  localparam logic [4:0] IA_CAPTURE3 = 5'h03;
  localparam logic [4:0] IA_CTRL = 5'h04;
  localparam logic [4:0] IA_OSC_CTRL = 5'h05;
  localparam logic [4:0] IA_OSC_CFG = 5'h06;
  localparam logic [4:0] IA_ALARM_CFG = 5'h07;
  localparam logic [4:0] IA_ALARM0 = 5'h08;
  localparam logic [4:0] IA_ALARM_LAST = 5'h13;
  localparam int NUM_ALARMS = 3;
  localparam int ALARM_BYTES = 12;

  // Timer control bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SET_BIT = 1;
  localparam int CTRL_CAPTURE_BIT = 2;
  localparam int CTRL_MCD_EN_BIT = 3;

  // Oscillator control and configuration bits
  localparam int OSCC_VALID_BIT = 7;
  localparam int OSCF_AUTOSTEP_BIT = 7;
  localparam int OSCF_LOADRDY_BIT = 6;
  localparam int LOADCAP_W = 4;

  // Alarm configuration: enables in 2:0, flags in 6:4
  localparam int ACFG_EN_LSB = 0;
  localparam int ACFG_FLAG_LSB = 4;

  // Missing-clock timeout
  localparam int CLK_FREQ_MHZ = 20;
  localparam int MISS_TIME_US = 100;
  localparam int MISS_CYCLES = MISS_TIME_US * CLK_FREQ_MHZ;
  localparam int MISS_CNT_W = 12;

  // One processor access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtci_sfr_req_type;

endpackage : rtci_pkg

// ==== rtl/rtci_indirect_access.sv ====
// Indirect access interface and register space of a 32-bit real time clock.
// Assumes the processor issues at most one read or write strobe per cycle and
// the low-frequency timebase is an asynchronous level on i_lf_clk.

// What this block does
// - Four capture bytes at 0x00-0x03 load the timer and read its count.
// - Timer control at 0x04, oscillator control 0x05, oscillator configuration 0x06.
// - Alarm configuration at 0x07 holds enable and flag per alarm.
// - Three 32-bit alarms in byte registers 0x08-0x0B, 0x0C-0x0F, 0x10-0x13.
// - Internal registers are reachable only through address and data registers.
// - Key register writes are ignored; interface is always unlocked.
// - Reading the key register returns 0x02.
// - Address bits 4:0 select the internal register for later accesses.
// - Writing the data register writes that byte to the selected register.
// - Software writes the address, then data reads return the selected register.
// - With autoread bit 6 set, each data read starts the next indirect read.
// - Address increments after each capture or alarm data write, and after indirect reads only with autoread set.
// - Address bits 7 and 5 read zero and ignore writes.
// - Alarm and missing-clock events are offered as reset or wake sources.
// - Load capacitance has sixteen settings chosen by configuration.
// - Data register moves one byte; no read-modify-write on it.
module rtci_indirect_access
  import rtci_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Special-function register bus
  input wire rtci_sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Low-frequency timebase
  input wire logic i_lf_clk,
  // Events and oscillator setting
  output logic o_alarm_event,
  output logic o_missing_clock,
  output logic [LOADCAP_W-1:0] o_loadcap
);

  function automatic logic rtci_autoinc(input logic [4:0] a);
    rtci_autoinc = (a <= IA_CAPTURE3) || (a >= IA_ALARM0 && a <= IA_ALARM_LAST);
  endfunction : rtci_autoinc

  function automatic logic [4:0] rtci_next_addr(input logic [4:0] a);
    rtci_next_addr = rtci_autoinc(a) ? a + 5'h01 : a;
  endfunction : rtci_next_addr

  // Interface registers
  logic [ADR_FIELD_W-1:0] addr_q;
  logic autoread_enable_q;
  logic [7:0] data_q;
  logic [7:0] rdata_q;

  // Internal registers
  logic [7:0] capture_q [0:3];
  logic [7:0] alarm_q [0:ALARM_BYTES-1];
  logic [7:0] ctrl_q;
  logic [7:0] osc_ctrl_q;
  logic [7:0] osc_cfg_q;
  logic [NUM_ALARMS-1:0] alarm_en_q;
  logic [NUM_ALARMS-1:0] alarm_flag_q;
  logic [31:0] timer_q;
  logic [LOADCAP_W-1:0] loadcap_q;

  // Timebase synchroniser and missing-clock state
  logic lf_s1_q;
  logic lf_s2_q;
  logic lf_s3_q;
  logic [MISS_CNT_W-1:0] miss_cnt_q;
  logic miss_q;
  logic [NUM_ALARMS-1:0] match_q;
  logic alarm_event_q;

  // Bus decode
  wire adr_wr = i_sfr.wr && i_sfr.addr == SFR_ADDR_SELECT;
  wire dat_wr = i_sfr.wr && i_sfr.addr == SFR_DATA_PORT;
  wire dat_rd = i_sfr.rd && i_sfr.addr == SFR_DATA_PORT;
  wire auto_rd = dat_rd && autoread_enable_q;
  wire ind_rd = adr_wr || auto_rd;
  // A plain address write only prefetches, so a following data write lands on it
  wire ind_step = auto_rd || (adr_wr && i_sfr.wdata[ADR_AUTOREAD_ENABLE_BIT]);
  // A new address write selects the new target at once
  wire [4:0] sel_addr = adr_wr ? i_sfr.wdata[ADR_FIELD_W-1:0] : addr_q;

  // Internal write strobes
  wire wr_ctrl = dat_wr && addr_q == IA_CTRL;
  wire wr_oscc = dat_wr && addr_q == IA_OSC_CTRL;
  wire wr_oscf = dat_wr && addr_q == IA_OSC_CFG;
  wire wr_acfg = dat_wr && addr_q == IA_ALARM_CFG;
  wire wr_cap = dat_wr && addr_q <= IA_CAPTURE3;
  wire wr_alm = dat_wr && addr_q >= IA_ALARM0 && addr_q <= IA_ALARM_LAST;
  wire [3:0] alm_idx = 4'(addr_q - IA_ALARM0);
  wire [1:0] cap_idx = addr_q[1:0];

  // Timebase edge seen after two synchronising flops
  wire lf_tick = lf_s2_q ^ lf_s3_q;
  wire set_req = wr_ctrl && i_sfr.wdata[CTRL_SET_BIT];
  wire cap_req = wr_ctrl && i_sfr.wdata[CTRL_CAPTURE_BIT];
  wire run = ctrl_q[CTRL_RUN_BIT];
  wire mcd_en = ctrl_q[CTRL_MCD_EN_BIT];

  // Alarm compare, little-endian bytes
  logic [NUM_ALARMS-1:0] match;
  always_comb begin
    for (int n = 0; n < NUM_ALARMS; n++) begin
      match[n] = timer_q == {alarm_q[n*4+3], alarm_q[n*4+2], alarm_q[n*4+1], alarm_q[n*4]};
    end
  end
  wire [NUM_ALARMS-1:0] alarm_hit = match & ~match_q & alarm_en_q;

  // Internal read mux; unmapped addresses read zero
  wire [3:0] sel_alm = 4'(sel_addr - IA_ALARM0);
  wire loadrdy = loadcap_q == osc_cfg_q[LOADCAP_W-1:0];
  wire [7:0] acfg_rd = {1'b0, alarm_flag_q, 1'b0, alarm_en_q};
  wire [7:0] oscc_rd = {~miss_q, osc_ctrl_q[OSCC_VALID_BIT-1:0]};
  wire [7:0] oscf_rd = {osc_cfg_q[OSCF_AUTOSTEP_BIT], loadrdy, osc_cfg_q[5:0]};
  logic [7:0] int_rd;
  always_comb begin
    case (sel_addr)
      IA_CTRL: int_rd = ctrl_q;
      IA_OSC_CTRL: int_rd = oscc_rd;
      IA_OSC_CFG: int_rd = oscf_rd;
      IA_ALARM_CFG: int_rd = acfg_rd;
      default: begin
        if (sel_addr <= IA_CAPTURE3) begin
          int_rd = capture_q[sel_addr[1:0]];
        end else if (sel_addr <= IA_ALARM_LAST) begin
          int_rd = alarm_q[sel_alm];
        end else begin
          int_rd = 8'h00;
        end
      end
    endcase
  end

  // Bus read mux; only three interface registers exist on the bus
  logic [7:0] sfr_rd;
  always_comb begin
    case (i_sfr.addr)
      SFR_KEY_STATUS: sfr_rd = KEY_UNLOCKED;
      SFR_ADDR_SELECT: sfr_rd = {1'b0, autoread_enable_q, 1'b0, addr_q};
      SFR_DATA_PORT: sfr_rd = data_q;
      default: sfr_rd = 8'h00;
    endcase
  end
  assign o_sfr_rdata = rdata_q;

  // Interface registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_q <= ADR_RESET[ADR_FIELD_W-1:0];
      autoread_enable_q <= ADR_RESET[ADR_AUTOREAD_ENABLE_BIT];
      data_q <= DATA_RESET;
      rdata_q <= DATA_RESET;
    end else if (i_ce) begin
      if (i_sfr.rd) begin
        rdata_q <= sfr_rd;
      end
      if (adr_wr) begin
        autoread_enable_q <= i_sfr.wdata[ADR_AUTOREAD_ENABLE_BIT];
      end
      if (ind_rd) begin
        data_q <= int_rd;
        addr_q <= ind_step ? rtci_next_addr(sel_addr) : sel_addr;
      end else if (dat_wr) begin
        data_q <= i_sfr.wdata;
        addr_q <= rtci_next_addr(addr_q);
      end
    end
  end

  // Capture and alarm byte storage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        capture_q[i] <= 8'h00;
      end
      for (int i = 0; i < ALARM_BYTES; i++) begin
        alarm_q[i] <= 8'h00;
      end
    end else if (i_ce) begin
      if (cap_req) begin
        for (int i = 0; i < 4; i++) begin
          capture_q[i] <= timer_q[i*8 +: 8];
        end
      end else if (wr_cap) begin
        capture_q[cap_idx] <= i_sfr.wdata;
      end
      if (wr_alm) begin
        alarm_q[alm_idx] <= i_sfr.wdata;
      end
    end
  end

  // Control, oscillator and alarm configuration
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= 8'h00;
      osc_ctrl_q <= 8'h00;
      osc_cfg_q <= 8'h00;
      alarm_en_q <= '0;
      alarm_flag_q <= '0;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        // Set and capture are one-shot commands
        ctrl_q <= i_sfr.wdata & ~(8'h01 << CTRL_SET_BIT) & ~(8'h01 << CTRL_CAPTURE_BIT);
      end
      if (wr_oscc) begin
        osc_ctrl_q <= i_sfr.wdata;
      end
      if (wr_oscf) begin
        osc_cfg_q <= i_sfr.wdata;
      end
      if (wr_acfg) begin
        alarm_en_q <= i_sfr.wdata[ACFG_EN_LSB +: NUM_ALARMS];
      end
      // Hardware set wins over a software clear in the same cycle
      if (wr_acfg) begin
        alarm_flag_q <= i_sfr.wdata[ACFG_FLAG_LSB +: NUM_ALARMS] & alarm_flag_q | alarm_hit;
      end else begin
        alarm_flag_q <= alarm_flag_q | alarm_hit;
      end
    end
  end

  // Timer and timebase synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lf_s1_q <= 1'b0;
      lf_s2_q <= 1'b0;
      lf_s3_q <= 1'b0;
      timer_q <= 32'h0000_0000;
    end else if (i_ce) begin
      lf_s1_q <= i_lf_clk;
      lf_s2_q <= lf_s1_q;
      lf_s3_q <= lf_s2_q;
      if (set_req) begin
        timer_q <= {capture_q[3], capture_q[2], capture_q[1], capture_q[0]};
      end else if (run && lf_tick && lf_s2_q) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end
  end

  // Load capacitance stepping: climb one setting per timebase edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      loadcap_q <= '0;
    end else if (i_ce) begin
      if (!osc_cfg_q[OSCF_AUTOSTEP_BIT] || loadcap_q > osc_cfg_q[LOADCAP_W-1:0]) begin
        loadcap_q <= osc_cfg_q[LOADCAP_W-1:0];
      end else if (lf_tick && !loadrdy) begin
        loadcap_q <= loadcap_q + 4'h1;
      end
    end
  end
  assign o_loadcap = loadcap_q;

  // Missing-clock detector; the count ignores timebase edges it cannot see
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      miss_cnt_q <= '0;
      miss_q <= 1'b0;
    end else if (i_ce) begin
      if (!mcd_en || lf_tick) begin
        miss_cnt_q <= '0;
        miss_q <= 1'b0;
      end else if (miss_cnt_q == MISS_CNT_W'(MISS_CYCLES - 1)) begin
        miss_q <= 1'b1;
      end else begin
        miss_cnt_q <= miss_cnt_q + 1'b1;
      end
    end
  end
  assign o_missing_clock = miss_q;

  // Alarm event pulse on a fresh enabled match
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      match_q <= '0;
      alarm_event_q <= 1'b0;
    end else if (i_ce) begin
      match_q <= match;
      alarm_event_q <= |alarm_hit;
    end
  end
  assign o_alarm_event = alarm_event_q;

endmodule : rtci_indirect_access

// ==== tb/rtci_sva.sv ====
// Port checker for the indirect access block, bound below.
// Assumes accesses are made while i_ce is high.
module rtci_sva
  import rtci_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Bus and timebase
  input wire rtci_sfr_req_type i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_lf_clk,
  // Events
  input wire logic o_alarm_event,
  input wire logic o_missing_clock
);
  logic lf_q;
  logic [11:0] quiet_q;
  wire rd_go = i_ce && i_sfr.rd;
  wire wr_go = i_ce && i_sfr.wr;
  wire rd_key = rd_go && i_sfr.addr == SFR_KEY_STATUS;
  wire rd_adr = rd_go && i_sfr.addr == SFR_ADDR_SELECT;
  wire rd_dat = rd_go && i_sfr.addr == SFR_DATA_PORT;
  wire wr_adr = wr_go && i_sfr.addr == SFR_ADDR_SELECT;
  wire wr_dat = wr_go && i_sfr.addr == SFR_DATA_PORT;
  wire rd_none = rd_go && !rd_key && !rd_adr && !rd_dat;

  // Address write steps only when it starts an autoread run
  function automatic logic [7:0] adr_next(input logic [7:0] d);
    logic [4:0] f;
    f = d[4:0];
    if (d[ADR_AUTOREAD_ENABLE_BIT] && (f <= IA_CAPTURE3 || (f >= IA_ALARM0 && f <= IA_ALARM_LAST)))
      f = f + 5'h01;
    return {1'b0, d[ADR_AUTOREAD_ENABLE_BIT], 1'b0, f};
  endfunction : adr_next

  // Raw timebase quiet time; saturates so it never wraps
  always_ff @(posedge i_clk) begin
    lf_q <= i_lf_clk;
    if (!i_rst_n || lf_q != i_lf_clk) quiet_q <= 12'h000;
    else if (quiet_q != 12'hfff) quiet_q <= quiet_q + 12'h001;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence adr_then_read;
    wr_adr ##1 rd_adr;
  endsequence
  sequence data_then_read;
    wr_dat ##1 rd_dat;
  endsequence

  key_read_a: assert property (rd_key |=> o_sfr_rdata == KEY_UNLOCKED)
    else $error("key status read wrong");
  rdata_hold_a: assert property (i_ce && !i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (rd_none |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  adr_bits_a: assert property (rd_adr |=> !o_sfr_rdata[7] && !o_sfr_rdata[5])
    else $error("address spare bits not zero");
  adr_readback_a: assert property (adr_then_read |=> o_sfr_rdata == adr_next($past(i_sfr.wdata, 2)))
    else $error("address readback wrong");
  data_echo_a: assert property (data_then_read |=> o_sfr_rdata == $past(i_sfr.wdata, 2))
    else $error("data port echo wrong");
  miss_clock_a: assert property ($rose(o_missing_clock) |-> quiet_q >= MISS_CYCLES - 2)
    else $error("missing clock raised early");
  alarm_pulse_a: assert property (o_alarm_event |=> !o_alarm_event)
    else $error("alarm event wider than a cycle");
endmodule : rtci_sva

bind rtci_indirect_access rtci_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .i_lf_clk(i_lf_clk),
  .o_alarm_event(o_alarm_event), .o_missing_clock(o_missing_clock));

// ==== tb/rtci_cpu_model.sv ====
// Processor side model: one register access per call.
// Assumes callers want back to back requests and release with idle.
module rtci_cpu_model
  import rtci_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Request
  output rtci_sfr_req_type o_sfr
);
  initial o_sfr = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

  // Plain moves only, never read-modify-write
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_sfr = '{wr: w, rd: !w, addr: a, wdata: d};
  endtask : acc

  // Released lines flip so stale values cannot pass
  task automatic idle;
    @(negedge i_clk);
    o_sfr = '{wr: 1'b0, rd: 1'b0, addr: ~o_sfr.addr, wdata: ~o_sfr.wdata};
  endtask : idle
endmodule : rtci_cpu_model

// ==== tb/rtci_indirect_access_tb.sv ====
// Self-checking bench for the indirect access block.
// Assumes rtci_cpu_model issues every bus request.
module rtci_indirect_access_tb
  import rtci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] AS = SFR_ADDR_SELECT;
  localparam logic [7:0] DP = SFR_DATA_PORT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lf_clk = 1'b0;
  logic lf_run = 1'b1;
  rtci_sfr_req_type sfr;
  logic [7:0] rdata;
  logic [7:0] b [12];
  logic [3:0] loadcap;
  logic [3:0] v;
  logic alarm_ev;
  logic miss;
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int n_compared = 0;

  always #25 clk = ~clk;
  // Timebase unrelated in phase to the system clock
  always #1003 if (lf_run) lf_clk = ~lf_clk;

  rtci_cpu_model cpu (.i_clk(clk), .o_sfr(sfr));
  rtci_indirect_access uut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .i_lf_clk(lf_clk), .o_alarm_event(alarm_ev),
    .o_missing_clock(miss), .o_loadcap(loadcap));

  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.acc(1'b0, a, 8'h00);
  endtask : rd

  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Read answers land one cycle after the strobe
  always @(posedge clk) begin
    if (sfr.rd) begin
      @(negedge clk);
      check("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(29554));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd(SFR_KEY_STATUS, KEY_UNLOCKED);
    wr(SFR_KEY_STATUS, 8'hff);
    rd(SFR_KEY_STATUS, KEY_UNLOCKED);
    rd(8'h80, 8'h00);
    wr(AS, 8'hff);
    rd(AS, 8'h5f);
    wr(AS, 8'h14);
    wr(DP, 8'ha5);
    rd(DP, 8'ha5);
    for (int i = 0; i < ALARM_BYTES; i++) b[i] = 8'($urandom);
    for (int k = 0; k < NUM_ALARMS; k++) begin
      wr(AS, 8'h08 + 8'(4 * k));
      for (int j = 0; j < 4; j++) wr(DP, b[4 * k + j]);
      rd(AS, 8'h0c + 8'(4 * k));
      wr(AS, 8'h48 + 8'(4 * k));
      for (int j = 0; j < 4; j++) rd(DP, b[4 * k + j]);
    end
    // Without autoread the buffered byte repeats and the field stays
    wr(AS, 8'h08);
    rd(AS, 8'h08);
    rd(DP, b[0]);
    rd(DP, b[0]);
    rd(AS, 8'h08);
    v = 4'($urandom);
    wr(AS, {3'b000, IA_OSC_CFG});
    wr(DP, {4'h0, v});
    cpu.idle();
    wr(AS, {3'b000, IA_OSC_CFG});
    rd(DP, {4'h4, v});
    cpu.idle();
    check("loadcap", {4'h0, loadcap}, {4'h0, v});
    // Timer from zero, alarm zero at five rising timebase edges
    wr(AS, 8'h00);
    repeat (4) wr(DP, 8'h00);
    wr(AS, 8'h08);
    wr(DP, 8'h05);
    repeat (3) wr(DP, 8'h00);
    wr(AS, {3'b000, IA_ALARM_CFG});
    wr(DP, 8'h01);
    wr(AS, {3'b000, IA_CTRL});
    wr(DP, 8'h0b);
    cpu.idle();
    for (int i = 0; i < 1000 && !alarm_ev; i++) @(negedge clk);
    check("alarm", {7'h00, alarm_ev}, 8'h01);
    wr(AS, {3'b000, IA_ALARM_CFG});
    rd(DP, 8'h11);
    cpu.idle();
    lf_run = 1'b0;
    for (int i = 0; i < 2200 && !miss; i++) @(negedge clk);
    check("miss", {7'h00, miss}, 8'h01);
    wrap_up();
  end
endmodule : rtci_indirect_access_tb
